// ### hw/cfg_bank_pkg.sv
// constants for the paged configuration register bank
package cfg_bank_pkg;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NUM_REGS = 128;
   localparam logic [ADDR_W-1:0] OFF_PAGE = 7'h00;
   localparam logic [ADDR_W-1:0] OFF_SOFT_RESET = 7'h01;
   localparam logic [ADDR_W-1:0] OFF_SLEEP = 7'h02;
   localparam logic [ADDR_W-1:0] OFF_SHUTDOWN = 7'h05;
   localparam logic [ADDR_W-1:0] OFF_SAI_A = 7'h07;
   localparam logic [ADDR_W-1:0] OFF_SAI_B = 7'h08;
   localparam logic [ADDR_W-1:0] OFF_SAI_C = 7'h09;
   localparam logic [ADDR_W-1:0] OFF_SAI_MIX = 7'h0a;
   localparam logic [ADDR_W-1:0] OFF_SLOT1 = 7'h0b;
   localparam logic [ADDR_W-1:0] OFF_SLOT2 = 7'h0c;
   localparam logic [ADDR_W-1:0] OFF_SLOT3 = 7'h0d;
   localparam logic [ADDR_W-1:0] OFF_SLOT4 = 7'h0e;
   localparam logic [ADDR_W-1:0] OFF_CLK_MST_A = 7'h13;
   localparam logic [ADDR_W-1:0] OFF_CLK_MST_B = 7'h14;
   localparam logic [ADDR_W-1:0] OFF_CLK_SELECT = 7'h16;
   localparam logic [ADDR_W-1:0] OFF_DMOD_CLK = 7'h1f;
   localparam logic [ADDR_W-1:0] OFF_DMOD_EDGE = 7'h20;
   localparam logic [ADDR_W-1:0] OFF_PIN_IO_CFG = 7'h21;
   localparam logic [ADDR_W-1:0] OFF_PIN_OUT_CFG = 7'h22;
   localparam logic [ADDR_W-1:0] OFF_PIN_OUT_VAL = 7'h29;
   localparam logic [ADDR_W-1:0] OFF_PIN_IN_CFG = 7'h2b;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CFG = 7'h32;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 7'h33;
   localparam logic [ADDR_W-1:0] OFF_CMODE_TOL = 7'h3a;
   localparam logic [ADDR_W-1:0] OFF_BIAS_CONV = 7'h3b;
   localparam logic [ADDR_W-1:0] OFF_CH1_A = 7'h3c;
   localparam logic [ADDR_W-1:0] OFF_CH1_B = 7'h3d;
   localparam logic [ADDR_W-1:0] OFF_CH1_C = 7'h3e;
   localparam logic [ADDR_W-1:0] OFF_CH1_D = 7'h3f;
   localparam logic [ADDR_W-1:0] OFF_CH1_E = 7'h40;
   localparam logic [ADDR_W-1:0] OFF_CH2_A = 7'h41;
   localparam logic [ADDR_W-1:0] OFF_CH2_B = 7'h42;
   localparam logic [ADDR_W-1:0] OFF_CH2_C = 7'h43;
   localparam logic [ADDR_W-1:0] OFF_CH2_D = 7'h44;
   localparam logic [ADDR_W-1:0] OFF_CH2_E = 7'h45;
   localparam logic [ADDR_W-1:0] OFF_CH3_C = 7'h48;
   localparam logic [ADDR_W-1:0] OFF_CH3_D = 7'h49;
   localparam logic [ADDR_W-1:0] OFF_CH3_E = 7'h4a;
   localparam logic [ADDR_W-1:0] OFF_CH4_C = 7'h4d;
   localparam logic [ADDR_W-1:0] OFF_CH4_D = 7'h4e;
   localparam logic [ADDR_W-1:0] OFF_CH4_E = 7'h4f;
   localparam logic [ADDR_W-1:0] OFF_SIGPROC_A = 7'h6b;
   localparam logic [ADDR_W-1:0] OFF_SIGPROC_B = 7'h6c;
   localparam logic [ADDR_W-1:0] OFF_RANGE_ENH = 7'h6d;
   localparam logic [ADDR_W-1:0] OFF_BUS_CLK_STS = 7'h15;
   localparam logic [ADDR_W-1:0] OFF_PIN_IO_MON = 7'h2a;
   localparam logic [ADDR_W-1:0] OFF_PIN_IN_MON = 7'h2f;
   localparam logic [ADDR_W-1:0] OFF_IRQ_LATCHED = 7'h36;
   localparam logic [DATA_W-1:0] PAGE_ZERO = 8'h00;
   localparam int unsigned SOFT_RESET_BIT = 0;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

   // one entry per page-0 offset: implemented, writable, reset value
   typedef struct packed {
      logic valid;
      logic writable;
      logic [DATA_W-1:0] rst;
   } reg_info_t;

   function automatic reg_info_t reg_info(input logic [ADDR_W-1:0] a);
      reg_info_t r;
      r = '{valid: 1'b1, writable: 1'b1, rst: 8'h00};
      case (a)
         7'h00, 7'h01, 7'h02, 7'h08, 7'h09, 7'h0a, 7'h0b: r.rst = 8'h00;
         7'h05: r.rst = 8'h05;
         7'h07: r.rst = 8'h30;
         7'h0c: r.rst = 8'h01;
         7'h0d: r.rst = 8'h02;
         7'h0e: r.rst = 8'h03;
         7'h13: r.rst = 8'h02;
         7'h14: r.rst = 8'h48;
         7'h15: r = '{valid: 1'b1, writable: 1'b0, rst: 8'hff};
         7'h16: r.rst = 8'h10;
         7'h1f: r.rst = 8'h40;
         7'h20, 7'h22, 7'h29, 7'h2b, 7'h32: r.rst = 8'h00;
         7'h21: r.rst = 8'h22;
         7'h2a, 7'h2f, 7'h36: r = '{valid: 1'b1, writable: 1'b0, rst: 8'h00};
         7'h33: r.rst = 8'hff;
         7'h3a, 7'h3b, 7'h3c, 7'h3d, 7'h40: r.rst = 8'h00;
         7'h41, 7'h42, 7'h45, 7'h4a, 7'h4f: r.rst = 8'h00;
         7'h3e, 7'h43, 7'h48, 7'h4d: r.rst = 8'hc9;
         7'h3f, 7'h44, 7'h49, 7'h4e: r.rst = 8'h80;
         7'h6b: r.rst = 8'h01;
         7'h6c: r.rst = 8'h40;
         7'h6d: r.rst = 8'h7b;
         default: r = '{valid: 1'b0, writable: 1'b0, rst: 8'h00};
      endcase
      return r;
   endfunction
endpackage

// ### hw/cfg_reg_cell.sv
// one eight-bit configuration register with its own reset value
`timescale 1ns/1ps
`default_nettype none
module cfg_reg_cell #(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter bit WRITABLE = 1'b1
) (
   input wire logic clk,
   input wire logic clear,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] status_in,
   output logic [7:0] value
);
   logic [7:0] value_q;

   // writable cells store host data; read-only cells track device status
   always_ff @(posedge clk) begin
      if (clear) begin
         value_q <= RST_VAL;
      end else if (WRITABLE && wr_en) begin
         value_q <= wr_data;
      end else if (!WRITABLE) begin
         value_q <= status_in;
      end
   end

   assign value = value_q;
endmodule
`default_nettype wire

// ### hw/paged_config_register_bank.sv
// page-0 configuration register bank with page select and software reset
// Operation
// - offset zero holds eight-bit page select, pages 0 to 255, reset zero.
// - software reset returns every register to its power-on default.
// - writing 1 to bit 0 at offset one resets all, bit self-clears.
// - upper seven reset-register bits read zero; host writes only zeros.
// - read-only fields ignore writes; read-write fields store; reset value applies.
// - channel config c resets to 0xc9, config d resets to 0x80.
// - interrupt mask and bus clock monitor status reset to all ones.
// - page select at offset zero on every page, always writable.
// - page 0 selected after power-up and after software reset.
`timescale 1ns/1ps
`default_nettype none
module paged_config_register_bank (
   input wire logic clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [cfg_bank_pkg::ADDR_W-1:0] addr,
   input wire logic [cfg_bank_pkg::DATA_W-1:0] wr_data,
   output logic [cfg_bank_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid,
   input wire logic [cfg_bank_pkg::DATA_W-1:0] bus_clk_status_in,
   input wire logic [cfg_bank_pkg::DATA_W-1:0] pin_io_status_in,
   input wire logic [cfg_bank_pkg::DATA_W-1:0] pin_in_status_in,
   input wire logic [cfg_bank_pkg::DATA_W-1:0] irq_latched_in,
   output logic [cfg_bank_pkg::DATA_W-1:0] active_page,
   output logic soft_reset_pulse,
   output logic [cfg_bank_pkg::NUM_REGS*cfg_bank_pkg::DATA_W-1:0] reg_image
);
   import cfg_bank_pkg::*;

   logic [DATA_W-1:0] page_q;
   logic soft_reset_q;
   logic clear;
   logic on_page0;
   logic page_wr;
   logic [DATA_W-1:0] regs [NUM_REGS];
   logic [DATA_W-1:0] rd_data_q;
   logic rd_valid_q;
   logic [DATA_W-1:0] status_sel [NUM_REGS];
   logic [DATA_W-1:0] rd_sel;
   logic [NUM_REGS-1:0] wr_hit;

   // power-on reset or pending software reset clears page select, reset bit and all cells; read data clears on power-on reset only
   assign clear = reset | soft_reset_q;
   assign on_page0 = (page_q == PAGE_ZERO);
   // page select is reachable at offset zero whatever page is active
   assign page_wr = wr_en && (addr == OFF_PAGE);

   // page select register, back to page 0 on any reset
   always_ff @(posedge clk) begin
      if (clear) begin
         page_q <= PAGE_ZERO;
      end else if (page_wr) begin
         page_q <= wr_data;
      end
   end

   // self-clearing software reset bit: set by writing 1, gone next cycle
   always_ff @(posedge clk) begin
      if (clear) begin
         soft_reset_q <= 1'b0;
      end else begin
         soft_reset_q <= wr_en && on_page0 && (addr == OFF_SOFT_RESET) && wr_data[SOFT_RESET_BIT];
      end
   end

   // device status feeding the read-only locations
   always_comb begin
      for (int i = 0; i < NUM_REGS; i++) begin
         status_sel[i] = ZERO_BYTE;
      end
      status_sel[OFF_BUS_CLK_STS] = bus_clk_status_in;
      status_sel[OFF_PIN_IO_MON] = pin_io_status_in;
      status_sel[OFF_PIN_IN_MON] = pin_in_status_in;
      status_sel[OFF_IRQ_LATCHED] = irq_latched_in;
   end

   // write decode: only writable page-0 offsets get a strobe
   always_comb begin
      wr_hit = '0;
      if (!wr_en || !on_page0) begin
         wr_hit = '0;
      // control
      end else if (addr == OFF_SLEEP) begin
         wr_hit[OFF_SLEEP] = 1'b1;
      end else if (addr == OFF_SHUTDOWN) begin
         wr_hit[OFF_SHUTDOWN] = 1'b1;
      // serial audio
      end else if (addr == OFF_SAI_A) begin
         wr_hit[OFF_SAI_A] = 1'b1;
      end else if (addr == OFF_SAI_B) begin
         wr_hit[OFF_SAI_B] = 1'b1;
      end else if (addr == OFF_SAI_C) begin
         wr_hit[OFF_SAI_C] = 1'b1;
      end else if (addr == OFF_SAI_MIX) begin
         wr_hit[OFF_SAI_MIX] = 1'b1;
      end else if (addr == OFF_SLOT1) begin
         wr_hit[OFF_SLOT1] = 1'b1;
      end else if (addr == OFF_SLOT2) begin
         wr_hit[OFF_SLOT2] = 1'b1;
      end else if (addr == OFF_SLOT3) begin
         wr_hit[OFF_SLOT3] = 1'b1;
      end else if (addr == OFF_SLOT4) begin
         wr_hit[OFF_SLOT4] = 1'b1;
      // clocking
      end else if (addr == OFF_CLK_MST_A) begin
         wr_hit[OFF_CLK_MST_A] = 1'b1;
      end else if (addr == OFF_CLK_MST_B) begin
         wr_hit[OFF_CLK_MST_B] = 1'b1;
      end else if (addr == OFF_BUS_CLK_STS) begin
         wr_hit = '0;
      end else if (addr == OFF_CLK_SELECT) begin
         wr_hit[OFF_CLK_SELECT] = 1'b1;
      end else if (addr == OFF_DMOD_CLK) begin
         wr_hit[OFF_DMOD_CLK] = 1'b1;
      end else if (addr == OFF_DMOD_EDGE) begin
         wr_hit[OFF_DMOD_EDGE] = 1'b1;
      // pins
      end else if (addr == OFF_PIN_IO_CFG) begin
         wr_hit[OFF_PIN_IO_CFG] = 1'b1;
      end else if (addr == OFF_PIN_OUT_CFG) begin
         wr_hit[OFF_PIN_OUT_CFG] = 1'b1;
      end else if (addr == OFF_PIN_OUT_VAL) begin
         wr_hit[OFF_PIN_OUT_VAL] = 1'b1;
      end else if (addr == OFF_PIN_IO_MON) begin
         wr_hit = '0;
      end else if (addr == OFF_PIN_IN_CFG) begin
         wr_hit[OFF_PIN_IN_CFG] = 1'b1;
      end else if (addr == OFF_PIN_IN_MON) begin
         wr_hit = '0;
      // interrupts
      end else if (addr == OFF_IRQ_CFG) begin
         wr_hit[OFF_IRQ_CFG] = 1'b1;
      end else if (addr == OFF_IRQ_MASK) begin
         wr_hit[OFF_IRQ_MASK] = 1'b1;
      end else if (addr == OFF_IRQ_LATCHED) begin
         wr_hit = '0;
      // analog front end
      end else if (addr == OFF_CMODE_TOL) begin
         wr_hit[OFF_CMODE_TOL] = 1'b1;
      end else if (addr == OFF_BIAS_CONV) begin
         wr_hit[OFF_BIAS_CONV] = 1'b1;
      // channel 1
      end else if (addr == OFF_CH1_A) begin
         wr_hit[OFF_CH1_A] = 1'b1;
      end else if (addr == OFF_CH1_B) begin
         wr_hit[OFF_CH1_B] = 1'b1;
      end else if (addr == OFF_CH1_C) begin
         wr_hit[OFF_CH1_C] = 1'b1;
      end else if (addr == OFF_CH1_D) begin
         wr_hit[OFF_CH1_D] = 1'b1;
      end else if (addr == OFF_CH1_E) begin
         wr_hit[OFF_CH1_E] = 1'b1;
      // channel 2
      end else if (addr == OFF_CH2_A) begin
         wr_hit[OFF_CH2_A] = 1'b1;
      end else if (addr == OFF_CH2_B) begin
         wr_hit[OFF_CH2_B] = 1'b1;
      end else if (addr == OFF_CH2_C) begin
         wr_hit[OFF_CH2_C] = 1'b1;
      end else if (addr == OFF_CH2_D) begin
         wr_hit[OFF_CH2_D] = 1'b1;
      end else if (addr == OFF_CH2_E) begin
         wr_hit[OFF_CH2_E] = 1'b1;
      // channel 3
      end else if (addr == OFF_CH3_C) begin
         wr_hit[OFF_CH3_C] = 1'b1;
      end else if (addr == OFF_CH3_D) begin
         wr_hit[OFF_CH3_D] = 1'b1;
      end else if (addr == OFF_CH3_E) begin
         wr_hit[OFF_CH3_E] = 1'b1;
      // channel 4
      end else if (addr == OFF_CH4_C) begin
         wr_hit[OFF_CH4_C] = 1'b1;
      end else if (addr == OFF_CH4_D) begin
         wr_hit[OFF_CH4_D] = 1'b1;
      end else if (addr == OFF_CH4_E) begin
         wr_hit[OFF_CH4_E] = 1'b1;
      // processing
      end else if (addr == OFF_SIGPROC_A) begin
         wr_hit[OFF_SIGPROC_A] = 1'b1;
      end else if (addr == OFF_SIGPROC_B) begin
         wr_hit[OFF_SIGPROC_B] = 1'b1;
      end else if (addr == OFF_RANGE_ENH) begin
         wr_hit[OFF_RANGE_ENH] = 1'b1;
      end else begin
         wr_hit = '0;
      end
   end

   // one cell per implemented page-0 offset except offsets 0 and 1; reserved offsets hold zero
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_cell
      localparam reg_info_t INFO = reg_info(ADDR_W'(g));
      if (INFO.valid && g != OFF_PAGE && g != OFF_SOFT_RESET) begin : g_impl
         cfg_reg_cell #(
            .RST_VAL(INFO.rst),
            .WRITABLE(INFO.writable)
         ) u_cell (
            .clk(clk),
            .clear(clear),
            .wr_en(wr_hit[g]),
            .wr_data(wr_data),
            .status_in(status_sel[g]),
            .value(regs[g])
         );
      end else if (g == OFF_PAGE) begin : g_page
         assign regs[g] = page_q;
      end else if (g == OFF_SOFT_RESET) begin : g_swrst
         // upper bits always read zero
         assign regs[g] = {{(DATA_W-1){1'b0}}, soft_reset_q};
      end else begin : g_rsvd
         assign regs[g] = ZERO_BYTE;
      end
      assign reg_image[g*DATA_W +: DATA_W] = regs[g];
   end

   // read decode: page select on every page, the map only on page 0
   always_comb begin
      rd_sel = ZERO_BYTE;
      if (addr == OFF_PAGE) begin
         rd_sel = page_q;
      end else if (!on_page0) begin
         rd_sel = ZERO_BYTE;
      // control
      end else if (addr == OFF_SOFT_RESET) begin
         rd_sel = regs[OFF_SOFT_RESET];
      end else if (addr == OFF_SLEEP) begin
         rd_sel = regs[OFF_SLEEP];
      end else if (addr == OFF_SHUTDOWN) begin
         rd_sel = regs[OFF_SHUTDOWN];
      // serial audio
      end else if (addr == OFF_SAI_A) begin
         rd_sel = regs[OFF_SAI_A];
      end else if (addr == OFF_SAI_B) begin
         rd_sel = regs[OFF_SAI_B];
      end else if (addr == OFF_SAI_C) begin
         rd_sel = regs[OFF_SAI_C];
      end else if (addr == OFF_SAI_MIX) begin
         rd_sel = regs[OFF_SAI_MIX];
      end else if (addr == OFF_SLOT1) begin
         rd_sel = regs[OFF_SLOT1];
      end else if (addr == OFF_SLOT2) begin
         rd_sel = regs[OFF_SLOT2];
      end else if (addr == OFF_SLOT3) begin
         rd_sel = regs[OFF_SLOT3];
      end else if (addr == OFF_SLOT4) begin
         rd_sel = regs[OFF_SLOT4];
      // clocking
      end else if (addr == OFF_CLK_MST_A) begin
         rd_sel = regs[OFF_CLK_MST_A];
      end else if (addr == OFF_CLK_MST_B) begin
         rd_sel = regs[OFF_CLK_MST_B];
      end else if (addr == OFF_BUS_CLK_STS) begin
         rd_sel = regs[OFF_BUS_CLK_STS];
      end else if (addr == OFF_CLK_SELECT) begin
         rd_sel = regs[OFF_CLK_SELECT];
      end else if (addr == OFF_DMOD_CLK) begin
         rd_sel = regs[OFF_DMOD_CLK];
      end else if (addr == OFF_DMOD_EDGE) begin
         rd_sel = regs[OFF_DMOD_EDGE];
      // pins
      end else if (addr == OFF_PIN_IO_CFG) begin
         rd_sel = regs[OFF_PIN_IO_CFG];
      end else if (addr == OFF_PIN_OUT_CFG) begin
         rd_sel = regs[OFF_PIN_OUT_CFG];
      end else if (addr == OFF_PIN_OUT_VAL) begin
         rd_sel = regs[OFF_PIN_OUT_VAL];
      end else if (addr == OFF_PIN_IO_MON) begin
         rd_sel = regs[OFF_PIN_IO_MON];
      end else if (addr == OFF_PIN_IN_CFG) begin
         rd_sel = regs[OFF_PIN_IN_CFG];
      end else if (addr == OFF_PIN_IN_MON) begin
         rd_sel = regs[OFF_PIN_IN_MON];
      // interrupts
      end else if (addr == OFF_IRQ_CFG) begin
         rd_sel = regs[OFF_IRQ_CFG];
      end else if (addr == OFF_IRQ_MASK) begin
         rd_sel = regs[OFF_IRQ_MASK];
      end else if (addr == OFF_IRQ_LATCHED) begin
         rd_sel = regs[OFF_IRQ_LATCHED];
      // analog front end
      end else if (addr == OFF_CMODE_TOL) begin
         rd_sel = regs[OFF_CMODE_TOL];
      end else if (addr == OFF_BIAS_CONV) begin
         rd_sel = regs[OFF_BIAS_CONV];
      // channel 1
      end else if (addr == OFF_CH1_A) begin
         rd_sel = regs[OFF_CH1_A];
      end else if (addr == OFF_CH1_B) begin
         rd_sel = regs[OFF_CH1_B];
      end else if (addr == OFF_CH1_C) begin
         rd_sel = regs[OFF_CH1_C];
      end else if (addr == OFF_CH1_D) begin
         rd_sel = regs[OFF_CH1_D];
      end else if (addr == OFF_CH1_E) begin
         rd_sel = regs[OFF_CH1_E];
      // channel 2
      end else if (addr == OFF_CH2_A) begin
         rd_sel = regs[OFF_CH2_A];
      end else if (addr == OFF_CH2_B) begin
         rd_sel = regs[OFF_CH2_B];
      end else if (addr == OFF_CH2_C) begin
         rd_sel = regs[OFF_CH2_C];
      end else if (addr == OFF_CH2_D) begin
         rd_sel = regs[OFF_CH2_D];
      end else if (addr == OFF_CH2_E) begin
         rd_sel = regs[OFF_CH2_E];
      // channel 3
      end else if (addr == OFF_CH3_C) begin
         rd_sel = regs[OFF_CH3_C];
      end else if (addr == OFF_CH3_D) begin
         rd_sel = regs[OFF_CH3_D];
      end else if (addr == OFF_CH3_E) begin
         rd_sel = regs[OFF_CH3_E];
      // channel 4
      end else if (addr == OFF_CH4_C) begin
         rd_sel = regs[OFF_CH4_C];
      end else if (addr == OFF_CH4_D) begin
         rd_sel = regs[OFF_CH4_D];
      end else if (addr == OFF_CH4_E) begin
         rd_sel = regs[OFF_CH4_E];
      // processing
      end else if (addr == OFF_SIGPROC_A) begin
         rd_sel = regs[OFF_SIGPROC_A];
      end else if (addr == OFF_SIGPROC_B) begin
         rd_sel = regs[OFF_SIGPROC_B];
      end else if (addr == OFF_RANGE_ENH) begin
         rd_sel = regs[OFF_RANGE_ENH];
      end else begin
         rd_sel = ZERO_BYTE;
      end
   end

   // registered read: page 0 decodes the map, other pages show only page select
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_q <= ZERO_BYTE;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd_en;
         if (rd_en) begin
            rd_data_q <= rd_sel;
         end
      end
   end

   assign rd_data = rd_data_q;
   assign rd_valid = rd_valid_q;
   assign active_page = page_q;
   assign soft_reset_pulse = soft_reset_q;
endmodule
`default_nettype wire

// ### bench/cfg_bank_assertions.sv
// port checks for the paged configuration register bank
`timescale 1ns/1ps
`default_nettype none
module cfg_bank_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [6:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic [7:0] pin_in_status_in,
   input wire logic [7:0] active_page,
   input wire logic soft_reset_pulse,
   input wire logic [1023:0] reg_image
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // a reset-bit write that the bank must act on
   wire logic hit = wr_en && addr == 7'h01 && wr_data[0] && active_page == 8'h00 && !soft_reset_pulse;
   wire logic quiet = !soft_reset_pulse;
   chk_read_answer: assert property (rd_en && quiet |=> rd_valid)
      else $error("read unanswered");
   chk_valid_cause: assert property (!rd_en |=> !rd_valid)
      else $error("stray valid");
   chk_page_load: assert property (wr_en && addr == 7'h00 && quiet |=> active_page == $past(wr_data))
      else $error("page not loaded");
   chk_page_read: assert property (rd_en && addr == 7'h00 && quiet |=> rd_data == $past(active_page))
      else $error("page misread");
   chk_reset_start: assert property (hit |=> soft_reset_pulse)
      else $error("no reset pulse");
   chk_reset_cause: assert property (!hit |=> !soft_reset_pulse)
      else $error("stray reset pulse");
   chk_reset_done: assert property (soft_reset_pulse |=> quiet && active_page == 8'h00 && reg_image[415:408] == 8'hff)
      else $error("defaults not restored");
   chk_upper_zero: assert property (reg_image[15:9] == 7'h00)
      else $error("reset bits not zero");
   chk_reserved_zero: assert property (reg_image[31:24] == 8'h00)
      else $error("reserved not zero");
   chk_ro_tracks: assert property (quiet |=> reg_image[383:376] == $past(pin_in_status_in))
      else $error("monitor stale");
   chk_status_default: assert property (soft_reset_pulse |=> reg_image[175:168] == 8'hff)
      else $error("status default lost");
   cover property (soft_reset_pulse);
   cover property (rd_valid && rd_data == 8'hc9);
   cover property (wr_en && addr == 7'h00 && wr_data != 8'h00);
endmodule
`default_nettype wire

// ### bench/host_model.sv
// register host driving the bank's access strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk,
   output logic wr_en,
   output logic rd_en,
   output logic [6:0] addr,
   output logic [7:0] wr_data
);
   initial begin
      {wr_en, rd_en, addr, wr_data} = '0;
   end
   // one access, launched and released on falling edges; pages change via offset 0
   task automatic put(input logic w, input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
      @(negedge clk);
      {wr_en, rd_en, addr, wr_data} = {2'b00, ~a, ~d};
   endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the paged configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk, reset, wr_en, rd_en, rd_valid, soft_reset_pulse;
   logic [6:0] addr;
   logic [7:0] wr_data, rd_data, active_page, bus_clk_status_in, pin_io_status_in, pin_in_status_in, irq_latched_in, v;
   logic [1023:0] reg_image;
   logic [14:0] q;
   logic [14:0] exp_q[$];
   logic [14:0] tab[8] = '{15'h0000, 15'h0100, 15'h0505, 15'h3ec9, 15'h3f80, 15'h33ff, 15'h6d7b, 15'h7000};
   int num_errors = 0, comparisons = 0, cycles = 0, seed = 33;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   host_model h (.clk, .wr_en, .rd_en, .addr, .wr_data);
   paged_config_register_bank dut_u (.clk, .reset, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_valid,
      .bus_clk_status_in, .pin_io_status_in, .pin_in_status_in, .irq_latched_in, .active_page, .soft_reset_pulse,
      .reg_image);
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back({a, e});
      h.put(1'b0, a, 8'h00);
   endtask
   task automatic summarize;
      if (exp_q.size() != 0) begin
         num_errors++;
         $display("[FAIL] pending reads expected 0 seen %0d", exp_q.size());
      end
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // each read answer is matched to the oldest noted expectation
   always @(negedge clk) begin
      if (rd_valid === 1'b1 && exp_q.size() > 0) begin
         q = exp_q.pop_front();
         check($sformatf("read %h", q[14:8]), q[7:0], rd_data);
      end else if (rd_valid === 1'b1) begin
         num_errors++;
         $display("[FAIL] read answer expected none seen %h", rd_data);
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         summarize();
      end
   end
   initial begin
      reset = 1'b1;
      {bus_clk_status_in, pin_io_status_in, pin_in_status_in, irq_latched_in} = $random(seed);
      repeat (10) @(negedge clk);
      reset = 1'b0;
      foreach (tab[i])
         rd(tab[i][14:8], tab[i][7:0]);
      rd(7'h15, bus_clk_status_in);
      v = 8'($random(seed));
      h.put(1'b1, 7'h3e, v);
      h.put(1'b1, 7'h2a, ~pin_io_status_in);
      h.put(1'b1, 7'h03, 8'h00);
      h.put(1'b1, 7'h01, 8'h00);
      rd(7'h3e, v);
      rd(7'h2a, pin_io_status_in);
      rd(7'h03, 8'h00);
      h.put(1'b1, 7'h01, 8'h01);
      check("reset pulse", 8'h01, {7'h00, soft_reset_pulse});
      @(negedge clk);
      rd(7'h3e, 8'hc9);
      rd(7'h01, 8'h00);
      v = 8'($random(seed)) | 8'h01;
      h.put(1'b1, 7'h00, v);
      h.put(1'b1, 7'h3e, 8'h11);
      rd(7'h00, v);
      rd(7'h3e, 8'h00);
      h.put(1'b1, 7'h00, 8'h00);
      rd(7'h3e, 8'hc9);
      h.put(1'b1, 7'h00, 8'hff);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      check("page after reset", 8'h00, active_page);
      repeat (3) @(negedge clk);
      summarize();
   end
endmodule
bind paged_config_register_bank cfg_bank_checker chk_u (.clk, .reset, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
   .rd_valid, .pin_in_status_in, .active_page, .soft_reset_pulse, .reg_image);
`default_nettype wire
